// [verilog/anro_overlay.sv]
// Read-data overlay: config registers, boot latch and read substitution.
// Assumes RF command decode, user memory and boot logic share clk_sys.
//
// What this block does
// R1: Config bit 0 adds the UID text field; factory zero.
// R2: Config bit 1 adds the eight-character custom field; factory zero.
// R3: Config bit 2 adds the tap code field; bit 3 reserved, reads zero.
// R4: Config bit 4 adds tamper status; forced zero without tamper interface.
// R5: Config bit 5 enables separators between present fields; factory one.
// R6: Config bits 15-8 give start block, bits 7-6 start byte; zero.
// R7: Separator register supplies the separator character; factory 78h.
// R8: Separator and custom registers need open session and clear lock.
// R9: Separator and custom writes act at once, no boot needed.
// R10: Custom low register holds first four characters; factory 2E2E2E2Eh.
// R11: Custom high register holds last four characters; factory 2E2E2E2Eh.
// R12: 128-bit UID text holds the identifier as ASCII characters.
// R13: UID text has no write path; seen only through overlaid reads.
// R14: Overlay state follows enable value latched at the last boot.
// R15: Active overlay replaces read bytes from first through last byte.
// R16: Block security status in read answers is never altered.
// R17: Block writes bypass the overlay and go straight to user memory.
// R18: Inactive overlay returns user memory only; last block 4Fh or 0Fh.
// R19: First byte is block*4+byte; last is min of end and first+len-1.
// R20: Length sums 16, 8, 3, 3 per field plus separators between them.
// R21: Field order UID, custom low, custom high, tap code, tamper.
// R22: Multi-byte values are placed least significant byte first.
// R23: Overlaid byte is virtual byte at address minus first byte.
module anro_overlay
	import anro_pkg::*;
#(
	parameter logic [7:0] LAST_BLOCK = LAST_BLOCK_LARGE,
	parameter bit HAS_TAMPER = 1'b1
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic bootStrobe,
	input wire logic sessionOpen,
	input wire logic overlayCfgLock,
	input wire logic cfgReq,
	input wire logic cfgWrite,
	input wire logic [2:0] cfgParam,
	input wire logic [31:0] cfgWdata,
	output logic cfgDone,
	output logic cfgErr,
	output logic [31:0] cfgRdata,
	input wire logic [127:0] uidText,
	input wire logic [23:0] tapCode,
	input wire logic [23:0] tamperStatus,
	input wire logic rdReq,
	input wire logic [7:0] rdBlock,
	input wire logic [31:0] umRdData,
	input wire logic [7:0] umRdBss,
	output logic rdDone,
	output anro_rdresp_s rdResp,
	input wire logic wrReq,
	input wire logic [7:0] wrBlock,
	input wire logic [31:0] wrData,
	output logic umWrEn,
	output logic [7:0] umWrBlock,
	output logic [31:0] umWrData,
	output logic overlayActive
);

	if (LAST_BLOCK > 8'hFE) begin : gBadLast
		$error("LAST_BLOCK leaves no room for the address arithmetic");
	end

	// Stored registers
	logic overlayEnable;
	anro_cfg_s overlayConfig;
	logic [7:0] separatorChar;
	logic [31:0] customTextLow;
	logic [31:0] customTextHigh;

	// Values latched at the last boot
	logic activeEn;
	anro_cfg_s activeCfg;

	// Access decode
	logic cfgAllowed;
	logic cfgKnown;
	logic cfgGuarded;
	logic cfgRefused;
	logic cfgWrOk;
	anro_cfg_s writtenCfg;
	logic [31:0] next_cfgRdata;

	// Overlay window
	logic [ADDR_W-1:0] overlayLength;
	logic [ADDR_W-1:0] firstByte;
	logic [ADDR_W-1:0] endCand;
	logic [ADDR_W-1:0] lastUserByte;
	logic [ADDR_W-1:0] lastByte;
	logic [31:0] next_rdData;

	assign cfgAllowed = sessionOpen && !overlayCfgLock; // R8
	assign cfgKnown = cfgParam <= PAR_CUS_HIGH;
	assign cfgGuarded = cfgParam >= PAR_SEP;

	always_comb begin
		cfgRefused = 1'b0;
		if (!cfgKnown) begin
			cfgRefused = 1'b1;
		end else if (cfgWrite) begin
			cfgRefused = !cfgAllowed; // R8
		end else if (cfgGuarded) begin
			cfgRefused = !cfgAllowed; // R8
		end
	end

	assign cfgWrOk = cfgReq && cfgWrite && !cfgRefused;

	// Reserved bit and missing tamper interface read back as zero
	always_comb begin
		writtenCfg = anro_cfg_s'(cfgWdata[15:0]);
		writtenCfg.rsvd = 1'b0; // R3
		if (!HAS_TAMPER) begin
			writtenCfg.tamperEn = 1'b0; // R4
		end
	end

	// Enable register, acts only at the next boot
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			overlayEnable <= EN_RESET;
		end else if (cfgWrOk && cfgParam == PAR_ENABLE) begin
			overlayEnable <= cfgWdata[0];
		end
	end

	// Configuration register, acts only at the next boot
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			overlayConfig <= anro_cfg_s'(CFG_RESET); // R1 R2 R5 R6
			if (!HAS_TAMPER) begin
				overlayConfig.tamperEn <= 1'b0; // R4
			end
		end else if (cfgWrOk && cfgParam == PAR_CONFIG) begin
			overlayConfig <= writtenCfg; // R1 R2 R3 R4 R5 R6
		end
	end

	// Separator and custom text, effective at once
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			separatorChar <= SEP_RESET; // R7
		end else if (cfgWrOk && cfgParam == PAR_SEP) begin
			separatorChar <= cfgWdata[7:0]; // R9
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			customTextLow <= CUSTOM_RESET; // R10
		end else if (cfgWrOk && cfgParam == PAR_CUS_LOW) begin
			customTextLow <= cfgWdata; // R9 R10
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			customTextHigh <= CUSTOM_RESET; // R11
		end else if (cfgWrOk && cfgParam == PAR_CUS_HIGH) begin
			customTextHigh <= cfgWdata; // R9 R11
		end
	end

	// Config read data; UID text has no entry here
	always_comb begin
		next_cfgRdata = 32'h0000_0000;
		case (cfgParam)
			PAR_ENABLE: next_cfgRdata = {31'h0000_0000, overlayEnable};
			PAR_CONFIG: next_cfgRdata = {16'h0000, overlayConfig};
			PAR_SEP: next_cfgRdata = {24'h00_0000, separatorChar};
			PAR_CUS_LOW: next_cfgRdata = customTextLow;
			PAR_CUS_HIGH: next_cfgRdata = customTextHigh;
			default: next_cfgRdata = 32'h0000_0000; // R13
		endcase
	end

	// Config command answer, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cfgDone <= 1'b0;
			cfgErr <= 1'b0;
			cfgRdata <= 32'h0000_0000;
		end else begin
			cfgDone <= cfgReq;
			cfgErr <= cfgReq && cfgRefused; // R8
			if (cfgReq && !cfgWrite && !cfgRefused) begin
				cfgRdata <= next_cfgRdata;
			end else begin
				cfgRdata <= 32'h0000_0000;
			end
		end
	end

	// Boot latch of enable and configuration
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			activeEn <= EN_RESET;
			activeCfg <= anro_cfg_s'(CFG_RESET);
		end else if (bootStrobe) begin
			activeEn <= overlayEnable; // R14
			activeCfg <= overlayConfig; // R19
		end
	end

	assign overlayActive = activeEn;

	// Window bounds from the latched configuration
	assign firstByte = {1'b0, activeCfg.startBlock, activeCfg.startByte}; // R19
	assign endCand = firstByte + overlayLength - 11'h001; // R19
	assign lastUserByte = {1'b0, LAST_BLOCK, 2'b11}; // R18
	assign lastByte = (endCand < lastUserByte) ? endCand : lastUserByte; // R19

	// Per-byte substitution of the block read
	for (genvar b = 0; b < 4; b++) begin : gByte
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] idx;
		logic hit;
		logic [7:0] vb;
		logic [ADDR_W-1:0] len;

		assign addr = {1'b0, rdBlock, 2'(b)};
		assign idx = addr - firstByte; // R23
		assign hit = activeEn && overlayLength != '0 &&
				addr >= firstByte && addr <= lastByte; // R15 R18

		anro_vbyte uVbyte (
			.cfg(activeCfg),
			.sepChar(separatorChar),
			.customLow(customTextLow),
			.customHigh(customTextHigh),
			.uidText(uidText),
			.tapCode(tapCode),
			.tamperStatus(tamperStatus),
			.idx(idx),
			.vByte(vb),
			.vLen(len)
		);

		assign next_rdData[8*b +: 8] = hit ? vb : umRdData[8*b +: 8]; // R15
		if (b == 0) begin : gLen
			assign overlayLength = len; // R20
		end
	end

	// Block read answer, one cycle after the request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdDone <= 1'b0;
			rdResp <= '0;
		end else begin
			rdDone <= rdReq;
			if (rdReq) begin
				rdResp.data <= next_rdData; // R15 R18
				rdResp.block_security_status <= umRdBss; // R16
			end
		end
	end

	// Block writes pass through untouched
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			umWrEn <= 1'b0;
			umWrBlock <= 8'h00;
			umWrData <= 32'h0000_0000;
		end else begin
			umWrEn <= wrReq; // R17
			if (wrReq) begin
				umWrBlock <= wrBlock; // R17
				umWrData <= wrData; // R17
			end
		end
	end

	// Checks
	default clocking cbSys @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence sGuardedWrite(logic [2:0] par);
		cfgReq && cfgWrite && cfgParam == par;
	endsequence

	sequence sRead;
		rdReq ##1 rdDone;
	endsequence

	a_cfg_locked_sep: assert property ( // R8
		sGuardedWrite(PAR_SEP) and !cfgAllowed |=>
			$stable(separatorChar) && cfgErr && cfgDone)
		else $error("Separator changed while access was refused");

	a_sep_write_now: assert property ( // R9
		sGuardedWrite(PAR_SEP) and cfgAllowed |=>
			separatorChar == $past(cfgWdata[7:0]) && !cfgErr)
		else $error("Separator write did not take effect at once");

	a_custom_write_now: assert property ( // R9
		sGuardedWrite(PAR_CUS_LOW) and cfgAllowed |=>
			customTextLow == $past(cfgWdata))
		else $error("Custom low write did not take effect at once");

	a_active_boot_only: assert property ( // R14
		!bootStrobe |=> $stable(activeEn) && $stable(activeCfg))
		else $error("Overlay state changed outside a boot");

	a_boot_latch_value: assert property ( // R14
		bootStrobe |=> activeEn == $past(overlayEnable))
		else $error("Boot did not latch the overlay enable");

	a_rd_bss_kept: assert property ( // R16
		sRead |-> rdResp.block_security_status == $past(umRdBss))
		else $error("Block security status was altered");

	a_inactive_pass: assert property ( // R18
		rdReq && !activeEn |=> rdDone && rdResp.data == $past(umRdData))
		else $error("Inactive overlay altered read data");

	a_wr_direct: assert property ( // R17
		wrReq |=> umWrEn && umWrData == $past(wrData) &&
			umWrBlock == $past(wrBlock))
		else $error("Block write was not passed straight through");

	a_rsvd_zero: assert property ( // R3
		overlayConfig.rsvd == 1'b0 && (HAS_TAMPER || !overlayConfig.tamperEn))
		else $error("Reserved or absent tamper bit is set");

	a_last_clip: assert property ( // R19
		overlayLength != '0 && firstByte <= lastUserByte |->
			lastByte >= firstByte && lastByte <= lastUserByte &&
			lastByte - firstByte < overlayLength &&
			(lastByte == lastUserByte ||
			lastByte - firstByte == overlayLength - 11'h001))
		else $error("Overlay last byte not clipped correctly");

	a_first_virtual: assert property ( // R23
		rdReq && activeEn && activeCfg.uidEn && overlayLength != '0 &&
			firstByte <= lastByte &&
			{1'b0, rdBlock, 2'b00} == firstByte |=>
			rdResp.data[7:0] == $past(uidText[7:0]))
		else $error("First overlaid byte is not the first UID character");

endmodule : anro_overlay

// [verilog/anro_pkg.sv]
// Shared constants and types of the read-data overlay.
// Assumes one clock domain; all users import the whole package.
package anro_pkg;

	// Byte address width: covers block 255, byte 3, plus a carry bit
	localparam int unsigned ADDR_W = 11;

	// Field lengths in bytes
	localparam logic [ADDR_W-1:0] UID_LEN = 11'h010;
	localparam logic [ADDR_W-1:0] CUS_LEN = 11'h008;
	localparam logic [ADDR_W-1:0] TAP_LEN = 11'h003;
	localparam logic [ADDR_W-1:0] TMP_LEN = 11'h003;
	localparam logic [ADDR_W-1:0] SEP_LEN = 11'h001;

	// Last user block of the two memory sizes
	localparam logic [7:0] LAST_BLOCK_LARGE = 8'h4F;
	localparam logic [7:0] LAST_BLOCK_SMALL = 8'h0F;

	// Factory values
	localparam logic EN_RESET = 1'b0;
	localparam logic [15:0] CFG_RESET = 16'h0020;
	localparam logic [7:0] SEP_RESET = 8'h78;
	localparam logic [31:0] CUSTOM_RESET = 32'h2E2E2E2E;

	// Configuration field positions
	localparam int unsigned CFG_UID_BIT = 0;
	localparam int unsigned CFG_CUS_BIT = 1;
	localparam int unsigned CFG_TAP_BIT = 2;
	localparam int unsigned CFG_RSVD_BIT = 3;
	localparam int unsigned CFG_TMP_BIT = 4;
	localparam int unsigned CFG_SEP_BIT = 5;
	localparam int unsigned CFG_BYTE_LSB = 6;
	localparam int unsigned CFG_BLOCK_LSB = 8;

	// Configuration parameter identifiers of the config commands
	typedef enum logic [2:0] {
		PAR_ENABLE = 3'h0,
		PAR_CONFIG = 3'h1,
		PAR_SEP = 3'h2,
		PAR_CUS_LOW = 3'h3,
		PAR_CUS_HIGH = 3'h4
	} anro_param_e;

	// Overlay configuration word, bit 0 at the bottom
	typedef struct packed {
		logic [7:0] startBlock;
		logic [1:0] startByte;
		logic sepEn;
		logic tamperEn;
		logic rsvd;
		logic tapEn;
		logic customEn;
		logic uidEn;
	} anro_cfg_s;

	// Block read answer
	typedef struct packed {
		logic [31:0] data;
		logic [7:0] block_security_status;
	} anro_rdresp_s;

endpackage : anro_pkg

// [verilog/anro_vbyte.sv]
// One byte of the virtual overlay memory, selected by index.
// Assumes the field sources are stable during the read cycle.
module anro_vbyte
	import anro_pkg::*;
(
	input wire anro_cfg_s cfg,
	input wire logic [7:0] sepChar,
	input wire logic [31:0] customLow,
	input wire logic [31:0] customHigh,
	input wire logic [127:0] uidText,
	input wire logic [23:0] tapCode,
	input wire logic [23:0] tamperStatus,
	input wire logic [ADDR_W-1:0] idx,
	output logic [7:0] vByte,
	output logic [ADDR_W-1:0] vLen
);

	logic [63:0] customCat;

	assign customCat = {customHigh, customLow}; // R21

	always_comb begin
		logic [ADDR_W-1:0] p;
		logic [ADDR_W-1:0] off;
		p = '0;
		off = '0;
		vByte = 8'h00;
		if (cfg.uidEn) begin
			off = idx - p;
			if (idx >= p && off < UID_LEN) begin
				vByte = uidText[{off[3:0], 3'b000} +: 8]; // R12 R22
			end
			p = p + UID_LEN; // R20
		end
		if (cfg.sepEn && cfg.uidEn && cfg.customEn) begin
			if (idx == p) begin
				vByte = sepChar; // R7 R21
			end
			p = p + SEP_LEN;
		end
		if (cfg.customEn) begin
			off = idx - p;
			if (idx >= p && off < CUS_LEN) begin
				vByte = customCat[{off[2:0], 3'b000} +: 8]; // R10 R11 R22
			end
			p = p + CUS_LEN;
		end
		if (cfg.sepEn && (cfg.uidEn || cfg.customEn) && cfg.tapEn) begin
			if (idx == p) begin
				vByte = sepChar; // R21
			end
			p = p + SEP_LEN;
		end
		if (cfg.tapEn) begin
			off = idx - p;
			if (idx >= p && off < TAP_LEN) begin
				vByte = tapCode[{off[1:0], 3'b000} +: 8]; // R3 R22
			end
			p = p + TAP_LEN;
		end
		if (cfg.sepEn && (cfg.uidEn || cfg.customEn || cfg.tapEn) &&
				cfg.tamperEn) begin
			if (idx == p) begin
				vByte = sepChar; // R21
			end
			p = p + SEP_LEN;
		end
		if (cfg.tamperEn) begin
			off = idx - p;
			if (idx >= p && off < TMP_LEN) begin
				vByte = tamperStatus[{off[1:0], 3'b000} +: 8]; // R4 R22
			end
			p = p + TMP_LEN;
		end
		vLen = p; // R20
	end

endmodule : anro_vbyte

// [test/anro_um_model.sv]
// User memory seen by the overlay: block data, status, write sink.
// Assumes the bench drives rdBlock; data follows it at once.
module anro_um_model
	import anro_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [7:0] rdBlock,
	output logic [31:0] umRdData,
	output logic [7:0] umRdBss,
	input wire logic umWrEn,
	input wire logic [7:0] umWrBlock,
	input wire logic [31:0] umWrData
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] mem [256];
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {8'(i), 8'(i) ^ 8'h5A, ~8'(i), 8'(i + 7)};
		end
	end
	// Status pattern known to the bench
	assign umRdBss = rdBlock ^ 8'h3C;
	assign umRdData = mem[rdBlock];
	always @(posedge clk_sys) begin
		if (umWrEn === 1'b1) begin
			mem[umWrBlock] <= umWrData;
		end
	end
endmodule : anro_um_model

// [test/tb.sv]
// Self-checking bench of the read-data overlay.
// Assumes a user memory model on the read and write ports.
module tb
	import anro_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] LB = 8'h0F;
	logic clk_sys = 0, rst_n = 0, bootStrobe = 0;
	logic sessionOpen = 0, overlayCfgLock = 0;
	logic cfgReq = 0, cfgWrite = 0, rdReq = 0, wrReq = 0;
	logic [2:0] cfgParam = 0;
	logic [31:0] cfgWdata = 0, wrData = 0, cfgRdata, umRdData, umWrData;
	logic [127:0] uidText = 0;
	logic [23:0] tapCode = 0, tamperStatus = 0;
	logic [7:0] rdBlock = 0, wrBlock = 0, umRdBss, umWrBlock;
	logic cfgDone, cfgErr, rdDone, umWrEn, overlayActive;
	anro_rdresp_s rdResp;
	int fails = 0, total_checks = 0;
	logic [32:0] cq [$];
	logic [39:0] rq [$], wq [$];
	logic [7:0] vm [$];
	logic en = 0, latEn = 0;
	logic [15:0] cfg = 16'h0020, lcfg = 16'h0020;
	logic [7:0] sep = 8'h78;
	logic [31:0] cl = 32'h2E2E2E2E, ch = 32'h2E2E2E2E;

	initial forever #5 clk_sys = ~clk_sys;

	anro_overlay #(.LAST_BLOCK(LB), .HAS_TAMPER(1'b1)) u_anro_overlay (
		.clk_sys(clk_sys), .rst_n(rst_n), .bootStrobe(bootStrobe),
		.sessionOpen(sessionOpen), .overlayCfgLock(overlayCfgLock),
		.cfgReq(cfgReq), .cfgWrite(cfgWrite), .cfgParam(cfgParam),
		.cfgWdata(cfgWdata), .cfgDone(cfgDone), .cfgErr(cfgErr),
		.cfgRdata(cfgRdata), .uidText(uidText), .tapCode(tapCode),
		.tamperStatus(tamperStatus), .rdReq(rdReq), .rdBlock(rdBlock),
		.umRdData(umRdData), .umRdBss(umRdBss), .rdDone(rdDone),
		.rdResp(rdResp), .wrReq(wrReq), .wrBlock(wrBlock),
		.wrData(wrData), .umWrEn(umWrEn), .umWrBlock(umWrBlock),
		.umWrData(umWrData), .overlayActive(overlayActive)
	);
	anro_um_model u_anro_um_model (
		.clk_sys(clk_sys), .rdBlock(rdBlock), .umRdData(umRdData),
		.umRdBss(umRdBss), .umWrEn(umWrEn), .umWrBlock(umWrBlock),
		.umWrData(umWrData)
	);

	task report(input string n, input logic [39:0] e, input logic [39:0] g);
		total_checks++;
		if (e !== g) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : report
	task chk_cfg(input logic [32:0] e, input logic [32:0] g);
		report("cfg", 40'(e), 40'(g));
	endtask : chk_cfg
	task chk_rd(input logic [39:0] e, input logic [39:0] g);
		report("read", e, g);
	endtask : chk_rd
	task chk_wr(input logic [39:0] e, input logic [39:0] g);
		report("write", e, g);
	endtask : chk_wr
	task chk_lvl(input logic e, input logic g);
		report("level", 40'(e), 40'(g));
	endtask : chk_lvl

	task tally_and_finish;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task idle;
		@(negedge clk_sys);
		{rdReq, wrReq, cfgReq, bootStrobe} = 4'h0;
	endtask : idle

	task cfg_op(input logic w, input logic [2:0] p, input logic [31:0] d);
		logic ok;
		logic [31:0] v;
		@(negedge clk_sys);
		{rdReq, wrReq, cfgReq, cfgWrite, cfgParam, cfgWdata} = {3'b001, w, p, d};
		ok = p < 3'h5 && (sessionOpen && !overlayCfgLock || !w && p < 3'h2);
		case (p)
			3'h0: v = {31'h0, en};
			3'h1: v = {16'h0, cfg};
			3'h2: v = {24'h0, sep};
			3'h3: v = cl;
			default: v = ch;
		endcase
		cq.push_back(ok ? {1'b0, w ? 32'h0 : v} : {1'b1, 32'h0});
		if (ok && w) begin
			case (p)
				3'h0: en = d[0];
				3'h1: cfg = d[15:0] & 16'hFFF7;
				3'h2: sep = d[7:0];
				3'h3: cl = d;
				default: ch = d;
			endcase
		end
	endtask : cfg_op

	// Virtual bytes from latched enables and current field values
	task mk;
		logic [63:0] cc;
		cc = {ch, cl};
		vm = {};
		if (lcfg[0]) for (int k = 0; k < 16; k++) vm.push_back(uidText[8*k+:8]);
		if (lcfg[0] && lcfg[1] && lcfg[5]) vm.push_back(sep);
		if (lcfg[1]) for (int k = 0; k < 8; k++) vm.push_back(cc[8*k+:8]);
		if ((lcfg[0] || lcfg[1]) && lcfg[2] && lcfg[5]) vm.push_back(sep);
		if (lcfg[2]) for (int k = 0; k < 3; k++) vm.push_back(tapCode[8*k+:8]);
		if (lcfg[2:0] != 0 && lcfg[4] && lcfg[5]) vm.push_back(sep);
		if (lcfg[4]) for (int k = 0; k < 3; k++) vm.push_back(tamperStatus[8*k+:8]);
	endtask : mk

	task rd_op(input logic [7:0] b);
		logic [31:0] d;
		int f, l, a;
		@(negedge clk_sys);
		{rdReq, wrReq, cfgReq, rdBlock} = {3'b100, b};
		d = u_anro_um_model.mem[b];
		mk();
		f = lcfg[15:8] * 4 + lcfg[7:6];
		l = f + vm.size() - 1;
		if (l > LB * 4 + 3) l = LB * 4 + 3;
		for (int k = 0; k < 4; k++) begin
			a = b * 4 + k;
			if (latEn && vm.size() > 0 && a >= f && a <= l) d[8*k+:8] = vm[a-f];
		end
		rq.push_back({d, b ^ 8'h3C});
	endtask : rd_op

	task wr_op(input logic [7:0] b, input logic [31:0] d);
		@(negedge clk_sys);
		{rdReq, wrReq, cfgReq, wrBlock, wrData} = {3'b010, b, d};
		wq.push_back({b, d});
	endtask : wr_op

	task boot;
		@(negedge clk_sys);
		{rdReq, wrReq, cfgReq, bootStrobe} = 4'h1;
		latEn = en;
		lcfg = cfg;
		idle();
		chk_lvl(latEn, overlayActive);
	endtask : boot

	always @(negedge clk_sys) begin
		if (cfgDone === 1'b1) chk_cfg(cq.size() ? cq.pop_front() : 'x, {cfgErr, cfgRdata});
		if (rdDone === 1'b1) chk_rd(rq.size() ? rq.pop_front() : 'x, rdResp);
		if (umWrEn === 1'b1) chk_wr(wq.size() ? wq.pop_front() : 'x, {umWrBlock, umWrData});
	end

	// Whole run is well under a thousand cycles
	initial begin
		#50000;
		fails++;
		tally_and_finish();
	end

	initial begin
		void'($urandom(32'h0F5A7040));
		repeat (8) @(negedge clk_sys);
		rst_n = 1;
		sessionOpen = 1;
		for (int p = 0; p < 8; p++) cfg_op(0, 3'(p), 0);
		cfg_op(1, 1, 32'h0000FFFF);
		cfg_op(0, 1, 0);
		idle();
		sessionOpen = 0;
		cfg_op(1, 2, 32'h41);
		cfg_op(0, 3, 0);
		cfg_op(1, 0, 1);
		cfg_op(0, 1, 0);
		idle();
		sessionOpen = 1;
		overlayCfgLock = 1;
		cfg_op(1, 4, 32'h41424344);
		cfg_op(0, 2, 0);
		idle();
		overlayCfgLock = 0;
		cfg_op(1, 0, 1);
		for (int b = 0; b <= LB + 1; b++) rd_op(8'(b));
		for (int i = 0; i < 16; i++) begin
			idle();
			uidText = {$urandom, $urandom, $urandom, $urandom};
			tapCode = 24'($urandom);
			tamperStatus = 24'($urandom);
			cfg_op(1, 0, {31'h0, i % 4 != 3});
			cfg_op(1, 1, {16'h0, 8'($urandom_range(0, LB)), 8'($urandom)});
			cfg_op(1, 2, $urandom);
			cfg_op(1, 3, $urandom);
			cfg_op(1, 4, $urandom);
			boot();
			for (int b = 0; b <= LB + 1; b++) begin
				rd_op(8'(b));
				if (b == 5) cfg_op(1, 2, $urandom);
				if (b == 9) cfg_op(1, 1, $urandom);
			end
			wr_op(lcfg[15:8], $urandom);
			rd_op(lcfg[15:8]);
		end
		repeat (3) idle();
		chk_lvl(1'b0, cq.size() + rq.size() + wq.size() != 0);
		tally_and_finish();
	end
endmodule : tb
